// >>> ubc_user_break.sv
// two-channel user break unit with eight-pair pc trace queue
`default_nettype none
module ubc_user_break
  import ubc_pkg::*;
(
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  // register port
  input  wire logic [7:0]     regAddr,
  input  wire logic [31:0]    regWdata,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic      [31:0]    regRdata,
  // monitored bus and instruction stream
  input  wire ubc_bus_type    busCyc,
  input  wire ubc_exec_type   execInfo,
  input  wire ubc_branch_type branchInfo,
  input  wire logic           branchDone,
  // break request to interrupt controller and cpu
  output logic                brkReq,
  output ubc_brk_type         brkType,
  output logic      [31:0]    brkPc
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic addrHit(input logic [31:0] a,
      input logic [31:0] bar, input logic [31:0] mask,
      input logic [1:0] sz);
    logic [31:0] care;
    care = ~mask;
    if (sz == SZ_LONG) care[1:0] = 2'h0;
    else if (sz == SZ_WORD) care[0] = 1'b0;
    return ((a ^ bar) & care) == 32'h00000000;
  endfunction

  function automatic logic cycleHit(input ubc_bbr_type c,
      input logic dma, input logic write, input logic [1:0] sz);
    // a 00 group (other than size, where 00 matches any size) never matches either side
    return (dma ? c.cpuDma[1] : c.cpuDma[0]) && c.fetchData[1]
        && (write ? c.readWrite[1] : c.readWrite[0])
        && (c.size == SZ_NONE || c.size == sz);
  endfunction

  function automatic logic fetchHit(input ubc_bbr_type c);
    return c.cpuDma[0] && c.fetchData[0] && c.readWrite[0]
        && c.size != SZ_BYTE;
  endfunction

  // ------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------
  ubc_bbr_type channel_a_bus_cycle_cond_q, channel_a_bus_cycle_cond_d, channel_b_bus_cycle_cond_q, channel_b_bus_cycle_cond_d;
  logic [31:0] ctl_q, ctl_d;
  logic [31:0] channel_a_break_address_q, channel_a_break_address_d, channel_a_address_mask_q, channel_a_address_mask_d;
  logic [31:0] channel_b_break_address_q, channel_b_break_address_d, channel_b_address_mask_q, channel_b_address_mask_d;
  logic [31:0] channel_b_break_data_q, channel_b_break_data_d, channel_b_data_mask_q, channel_b_data_mask_d;
  logic [7:0]  asidA_q, asidA_d, asidB_q, asidB_d;
  logic [15:0] execution_count_register_q, execution_count_register_d;
  logic        pendPre_q, pendPre_d, pendPost_q, pendPost_d;
  logic        pendData_q, pendData_d, seqArmed_q, seqArmed_d;
  logic        brkReq_q, brkReq_d;
  ubc_brk_type brkType_q, brkType_d;
  logic [31:0] brkPc_q, brkPc_d;
  ubc_src_type srcQ_q [TRACE_DEPTH];
  ubc_src_type srcQ_d [TRACE_DEPTH];
  ubc_dst_type dstQ_q [TRACE_DEPTH];
  ubc_dst_type dstQ_d [TRACE_DEPTH];
  logic [2:0]  rdPtr_q, rdPtr_d, trPtr_q, trPtr_d;
  logic        pcteOld_q, pcteOld_d;
  logic [31:0] regRdata_q, regRdata_d;

  // ------------------------------------------------------------
  // match evaluation
  // ------------------------------------------------------------
  logic asidOkA, asidOkB, dataOkB;
  logic datHitA, datHitB, fetHitA, fetHitB, hitA, hitB;
  logic seq, seqOk, cntOk, cntStep, aFire, bFire;
  logic preNow, postNow, dataNow, takeAt, fire;
  logic [31:0] dataCare, flagSet;

  assign seq = ctl_q[CTL_SEQ];
  assign asidOkA = ctl_q[CTL_ASID_OFF_A] || busCyc.asid == asidA_q;
  assign asidOkB = ctl_q[CTL_ASID_OFF_B] || busCyc.asid == asidB_q;
  // upper half only counts for longword data
  assign dataCare = ~channel_b_data_mask_q
      & (busCyc.size == SZ_LONG ? ~32'h00000000 : HALF_MASK);
  assign dataOkB = !ctl_q[CTL_DATA_EN_B] || (busCyc.size != SZ_NONE
      && ((busCyc.data ^ channel_b_break_data_q) & dataCare) == 32'h00000000);
  assign datHitA = busCyc.valid && asidOkA
      && cycleHit(channel_a_bus_cycle_cond_q, busCyc.isDma, busCyc.isWrite, busCyc.size)
      && addrHit(busCyc.addr, channel_a_break_address_q, channel_a_address_mask_q, busCyc.size);
  assign datHitB = busCyc.valid && asidOkB && dataOkB
      && cycleHit(channel_b_bus_cycle_cond_q, busCyc.isDma, busCyc.isWrite, busCyc.size)
      && addrHit(busCyc.addr, channel_b_break_address_q, channel_b_address_mask_q, busCyc.size);
  // fetch side looks at executed instructions only, never raw fetches,
  // so overrun fetches and data comparison cannot take part
  assign fetHitA = execInfo.valid && fetchHit(channel_a_bus_cycle_cond_q)
      && (ctl_q[CTL_ASID_OFF_A] || execInfo.asid == asidA_q)
      && addrHit(execInfo.addr, channel_a_break_address_q, channel_a_address_mask_q, SZ_BYTE);
  assign fetHitB = execInfo.valid && fetchHit(channel_b_bus_cycle_cond_q)
      && (ctl_q[CTL_ASID_OFF_B] || execInfo.asid == asidB_q)
      && addrHit(execInfo.addr, channel_b_break_address_q, channel_b_address_mask_q, SZ_BYTE);
  assign hitA = datHitA || fetHitA;
  assign hitB = datHitB || fetHitB;
  // B in the same cycle as the arming A does not count
  assign seqOk = !seq || seqArmed_q;
  assign cntOk = !ctl_q[CTL_COUNT_EN] || execution_count_register_q <= COUNT_ONE;
  assign cntStep = ctl_q[CTL_COUNT_EN] && hitB && seqOk && !cntOk;
  assign aFire = hitA && !seq;
  assign bFire = hitB && seqOk && cntOk;
  assign preNow = (aFire && fetHitA && !ctl_q[CTL_PCB_A])
      || (bFire && fetHitB && !ctl_q[CTL_PCB_B]);
  assign postNow = (aFire && fetHitA && ctl_q[CTL_PCB_A])
      || (bFire && fetHitB && ctl_q[CTL_PCB_B]);
  assign dataNow = (aFire && datHitA) || (bFire && datHitB);
  assign takeAt = execInfo.valid && execInfo.accept;
  assign fire = takeAt && (pendPre_q || preNow || pendPost_q
      || pendData_q);

  always_comb begin
    flagSet = 32'h00000000;
    flagSet[CTL_FLAG_CA] = fetHitA || (datHitA && !busCyc.isDma);
    flagSet[CTL_FLAG_CB] = fetHitB || (datHitB && !busCyc.isDma);
    flagSet[CTL_FLAG_DA] = datHitA && busCyc.isDma;
    flagSet[CTL_FLAG_DB] = datHitB && busCyc.isDma;
  end

  // ------------------------------------------------------------
  // control: bus cycle conditions and control register
  // ------------------------------------------------------------
  always_comb begin
    channel_a_bus_cycle_cond_d = channel_a_bus_cycle_cond_q;
    channel_b_bus_cycle_cond_d = channel_b_bus_cycle_cond_q;
    ctl_d = ctl_q;
    if (regWr && regAddr == OFF_BBR_A) channel_a_bus_cycle_cond_d = regWdata[7:0];
    if (regWr && regAddr == OFF_BBR_B) channel_b_bus_cycle_cond_d = regWdata[7:0];
    // a written 1 keeps a flag, a written 0 clears it
    if (regWr && regAddr == OFF_CTRL) begin
      ctl_d = (regWdata & ~CTL_FLAG_MASK)
          | (regWdata & ctl_q & CTL_FLAG_MASK);
    end
    // hardware set wins over a same-cycle clear
    ctl_d = ctl_d | flagSet;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      channel_a_bus_cycle_cond_q <= '0;
      channel_b_bus_cycle_cond_q <= '0;
      ctl_q <= CTL_RESET;
    end else begin
      channel_a_bus_cycle_cond_q <= channel_a_bus_cycle_cond_d;
      channel_b_bus_cycle_cond_q <= channel_b_bus_cycle_cond_d;
      ctl_q <= ctl_d;
    end
  end

  // ------------------------------------------------------------
  // settings: addresses, masks, ids, data, count (no reset)
  // ------------------------------------------------------------
  always_comb begin
    channel_a_break_address_d = channel_a_break_address_q;
    channel_a_address_mask_d = channel_a_address_mask_q;
    channel_b_break_address_d = channel_b_break_address_q;
    channel_b_address_mask_d = channel_b_address_mask_q;
    channel_b_break_data_d = channel_b_break_data_q;
    channel_b_data_mask_d = channel_b_data_mask_q;
    asidA_d = asidA_q;
    asidB_d = asidB_q;
    execution_count_register_d = cntStep ? execution_count_register_q - COUNT_ONE : execution_count_register_q;
    if (regWr) begin
      case (regAddr)
        OFF_ADDR_A: channel_a_break_address_d = regWdata;
        OFF_MASK_A: channel_a_address_mask_d = regWdata;
        OFF_ASID_A: asidA_d = regWdata[7:0];
        OFF_ADDR_B: channel_b_break_address_d = regWdata;
        OFF_MASK_B: channel_b_address_mask_d = regWdata;
        OFF_ASID_B: asidB_d = regWdata[7:0];
        OFF_DATA_B: channel_b_break_data_d = regWdata;
        OFF_DMSK_B: channel_b_data_mask_d = regWdata;
        OFF_COUNT: execution_count_register_d = regWdata[15:0];
        default: channel_a_break_address_d = channel_a_break_address_q;
      endcase
    end
  end

  // these hold whatever software last wrote (the count also steps down on B matches), reset leaves them alone
  always_ff @(posedge sys_clk) begin
    channel_a_break_address_q <= channel_a_break_address_d;
    channel_a_address_mask_q <= channel_a_address_mask_d;
    channel_b_break_address_q <= channel_b_break_address_d;
    channel_b_address_mask_q <= channel_b_address_mask_d;
    channel_b_break_data_q <= channel_b_break_data_d;
    channel_b_data_mask_q <= channel_b_data_mask_d;
    asidA_q <= asidA_d;
    asidB_q <= asidB_d;
    execution_count_register_q <= execution_count_register_d;
  end

  // ------------------------------------------------------------
  // break scheduling
  // ------------------------------------------------------------
  always_comb begin
    seqArmed_d = seq && (hitA || (seqArmed_q && !hitB));
    // one request retires every pending cause at once
    pendPre_d = (pendPre_q || preNow) && !fire;
    pendPost_d = (pendPost_q && !fire) || (postNow && !preNow);
    pendData_d = (pendData_q || dataNow) && !fire;
    brkReq_d = fire;
    brkType_d = brkType_q;
    brkPc_d = brkPc_q;
    if (fire) begin
      brkPc_d = execInfo.addr;
      if (pendPre_q || preNow) brkType_d = BRK_PRE;
      else if (pendPost_q) brkType_d = BRK_POST;
      else brkType_d = BRK_DATA;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seqArmed_q <= 1'b0;
      pendPre_q <= 1'b0;
      pendPost_q <= 1'b0;
      pendData_q <= 1'b0;
      brkReq_q <= 1'b0;
      brkType_q <= BRK_NONE;
      brkPc_q <= 32'h00000000;
    end else begin
      seqArmed_q <= seqArmed_d;
      pendPre_q <= pendPre_d;
      pendPost_q <= pendPost_d;
      pendData_q <= pendData_d;
      brkReq_q <= brkReq_d;
      brkType_q <= brkType_d;
      brkPc_q <= brkPc_d;
    end
  end

  // ------------------------------------------------------------
  // pc trace queue
  // ------------------------------------------------------------
  logic trace_enable, restart, push, dstRead;
  assign trace_enable = ctl_q[CTL_TRACE_EN];
  assign restart = trace_enable && !pcteOld_q;
  assign push = trace_enable && branchInfo.valid;
  assign dstRead = regRd && regAddr == OFF_DST_TR;

  always_comb begin
    srcQ_d = srcQ_q;
    dstQ_d = dstQ_q;
    rdPtr_d = rdPtr_q;
    trPtr_d = trPtr_q;
    pcteOld_d = trace_enable;
    if (dstRead) begin
      srcQ_d[rdPtr_q].valid = 1'b0;
      dstQ_d[rdPtr_q].destination_valid_flag = 1'b0;
      if (rdPtr_q != PTR_BOTTOM) rdPtr_d = rdPtr_q - PTR_STEP;
    end
    if (restart) begin
      for (int i = 0; i < TRACE_DEPTH; i++) begin
        srcQ_d[i].valid = 1'b0;
        dstQ_d[i].destination_valid_flag = 1'b0;
      end
      trPtr_d = PTR_BOTTOM;
    end
    if (push) begin
      if (dstQ_d[rdPtr_d].destination_valid_flag && rdPtr_d != PTR_TOP) begin
        rdPtr_d = rdPtr_d + PTR_STEP;
      end
      for (int i = TRACE_DEPTH - 1; i > 0; i--) begin
        srcQ_d[i] = srcQ_d[i-1];
        dstQ_d[i] = dstQ_d[i-1];
      end
      srcQ_d[0] = {1'b1, branchInfo.buffer_pointer, branchInfo.src};
      dstQ_d[0] = {1'b1, 3'h0, branchInfo.dst};
      if (trPtr_d != PTR_TOP) trPtr_d = trPtr_d + PTR_STEP;
    end else if (branchDone && trPtr_d != PTR_BOTTOM) begin
      trPtr_d = trPtr_d - PTR_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < TRACE_DEPTH; i++) begin
        srcQ_q[i].valid <= 1'b0;
        dstQ_q[i].destination_valid_flag <= 1'b0;
      end
      rdPtr_q <= PTR_BOTTOM;
      trPtr_q <= PTR_BOTTOM;
      pcteOld_q <= 1'b0;
    end else begin
      srcQ_q <= srcQ_d;
      dstQ_q <= dstQ_d;
      rdPtr_q <= rdPtr_d;
      trPtr_q <= trPtr_d;
      pcteOld_q <= pcteOld_d;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_comb begin
    regRdata_d = 32'h00000000;
    if (regRd) begin
      case (regAddr)
        OFF_ADDR_A: regRdata_d = channel_a_break_address_q;
        OFF_MASK_A: regRdata_d = channel_a_address_mask_q;
        OFF_BBR_A: regRdata_d = {24'h000000, channel_a_bus_cycle_cond_q};
        OFF_ASID_A: regRdata_d = {24'h000000, asidA_q};
        OFF_ADDR_B: regRdata_d = channel_b_break_address_q;
        OFF_MASK_B: regRdata_d = channel_b_address_mask_q;
        OFF_BBR_B: regRdata_d = {24'h000000, channel_b_bus_cycle_cond_q};
        OFF_ASID_B: regRdata_d = {24'h000000, asidB_q};
        OFF_DATA_B: regRdata_d = channel_b_break_data_q;
        OFF_DMSK_B: regRdata_d = channel_b_data_mask_q;
        OFF_CTRL: regRdata_d = ctl_q;
        OFF_COUNT: regRdata_d = {16'h0000, execution_count_register_q};
        OFF_SRC_TR: regRdata_d = srcQ_q[rdPtr_q];
        OFF_DST_TR: regRdata_d = dstQ_q[rdPtr_q];
        default: regRdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) regRdata_q <= 32'h00000000;
    else regRdata_q <= regRdata_d;
  end

  assign regRdata = regRdata_q;
  assign brkReq = brkReq_q;
  assign brkType = brkType_q;
  assign brkPc = brkPc_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic offA, offB;
  assign offA = channel_a_bus_cycle_cond_q.cpuDma == GRP_OFF || channel_a_bus_cycle_cond_q.fetchData == GRP_OFF
      || channel_a_bus_cycle_cond_q.readWrite == GRP_OFF;
  assign offB = channel_b_bus_cycle_cond_q.cpuDma == GRP_OFF || channel_b_bus_cycle_cond_q.fetchData == GRP_OFF
      || channel_b_bus_cycle_cond_q.readWrite == GRP_OFF;

  sequence sDataWithFetch;
    pendData_q && takeAt && (pendPre_q || preNow);
  endsequence
  sequence sPreTaken;
    brkReq_q && brkType_q == BRK_PRE;
  endsequence

  chk_group_off_quiet: assert property (
    offA && offB && !pendPre_q && !pendPost_q && !pendData_q
      |=> !brkReq_q)
    else $error("break raised with disabled channels");
  chk_flag_sticks: assert property (
    ctl_q[CTL_FLAG_CB] && !(regWr && regAddr == OFF_CTRL)
      |=> ctl_q[CTL_FLAG_CB])
    else $error("match flag dropped without software");
  chk_flag_sets: assert property (
    fetHitA |=> ctl_q[CTL_FLAG_CA])
    else $error("cpu match flag not set");
  chk_single_request: assert property (
    sDataWithFetch |=> sPreTaken and (!pendData_q))
    else $error("data and fetch breaks not merged");
  chk_only_on_exec: assert property (
    !takeAt |=> !brkReq_q)
    else $error("break outside accepting instruction");
  chk_pre_saved_pc: assert property (
    takeAt && preNow
      |=> sPreTaken and (brkPc_q == $past(execInfo.addr)))
    else $error("pre-execution break pc wrong");
  chk_post_next: assert property (
    takeAt && postNow && !preNow && !pendPre_q && !pendPost_q
      |=> pendPost_q && !(brkReq_q && brkType_q == BRK_POST))
    else $error("post break not deferred to next");
  chk_seq_same_cycle: assert property (
    seq && hitA && hitB && !seqArmed_q |-> !bFire ##1 seqArmed_q)
    else $error("simultaneous sequential match fired");
  chk_count_one: assert property (
    ctl_q[CTL_COUNT_EN] && hitB && seqOk && execution_count_register_q == COUNT_ONE
      |-> bFire)
    else $error("count of one did not break");
  chk_restart_ptrs: assert property (
    restart && !push && !dstRead && !branchDone
      |=> trPtr_q == PTR_BOTTOM && rdPtr_q == $past(rdPtr_q))
    else $error("trace restart pointers wrong");
  chk_read_clears: assert property (
    dstRead && !push && !restart |=> !dstQ_q[$past(rdPtr_q)].destination_valid_flag)
    else $error("destination valid not cleared by read");
endmodule
`default_nettype wire

// >>> ubc_pkg.sv
// shared constants and types for the user break and pc trace unit
`default_nettype none
package ubc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_ADDR_A = 8'h00;
  localparam logic [7:0] OFF_MASK_A = 8'h04;
  localparam logic [7:0] OFF_BBR_A  = 8'h08;
  localparam logic [7:0] OFF_ASID_A = 8'h0C;
  localparam logic [7:0] OFF_ADDR_B = 8'h10;
  localparam logic [7:0] OFF_MASK_B = 8'h14;
  localparam logic [7:0] OFF_BBR_B  = 8'h18;
  localparam logic [7:0] OFF_ASID_B = 8'h1C;
  localparam logic [7:0] OFF_DATA_B = 8'h20;
  localparam logic [7:0] OFF_DMSK_B = 8'h24;
  localparam logic [7:0] OFF_CTRL   = 8'h28;
  localparam logic [7:0] OFF_COUNT  = 8'h2C;
  localparam logic [7:0] OFF_SRC_TR = 8'h30;
  localparam logic [7:0] OFF_DST_TR = 8'h34;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CTL_ASID_OFF_A = 21;
  localparam int CTL_ASID_OFF_B = 20;
  localparam int CTL_FLAG_CA    = 15;
  localparam int CTL_FLAG_CB    = 14;
  localparam int CTL_FLAG_DA    = 13;
  localparam int CTL_FLAG_DB    = 12;
  localparam int CTL_TRACE_EN   = 11;
  localparam int CTL_PCB_A      = 10;
  localparam int CTL_DATA_EN_B  = 7;
  localparam int CTL_PCB_B      = 6;
  localparam int CTL_SEQ        = 3;
  localparam int CTL_COUNT_EN   = 0;
  localparam logic [31:0] CTL_FLAG_MASK = 32'h0000F000;
  localparam logic [31:0] CTL_RESET     = 32'h00000000;
  // ------------------------------------------------------------
  // sizes, pointers, counts
  // ------------------------------------------------------------
  localparam logic [1:0]  SZ_NONE    = 2'h0;
  localparam logic [1:0]  SZ_BYTE    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam logic [1:0]  SZ_LONG    = 2'h3;
  localparam logic [1:0]  GRP_OFF    = 2'h0;
  localparam logic [2:0]  PTR_TOP    = 3'h7;
  localparam logic [2:0]  PTR_BOTTOM = 3'h0;
  localparam logic [2:0]  PTR_STEP   = 3'h1;
  localparam int          TRACE_DEPTH = 8;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [31:0] HALF_MASK  = 32'h0000FFFF;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cpuDma; logic [1:0] fetchData;
    logic [1:0] readWrite; logic [1:0] size;
  } ubc_bbr_type;
  typedef struct packed {
    logic valid; logic isDma; logic isWrite; logic [1:0] size;
    logic [31:0] addr; logic [31:0] data; logic [7:0] asid;
  } ubc_bus_type;
  typedef struct packed {
    logic valid; logic accept; logic [31:0] addr; logic [7:0] asid;
  } ubc_exec_type;
  typedef struct packed {
    logic valid; logic [2:0] buffer_pointer; logic [27:0] src; logic [27:0] dst;
  } ubc_branch_type;
  typedef struct packed {
    logic valid; logic [2:0] buffer_pointer; logic [27:0] stored_source_address;
  } ubc_src_type;
  typedef struct packed {
    logic destination_valid_flag; logic [2:0] rsv; logic [27:0] bda;
  } ubc_dst_type;
  typedef enum logic [1:0] {
    BRK_NONE, BRK_PRE, BRK_POST, BRK_DATA
  } ubc_brk_type;
endpackage
`default_nettype wire

// >>> ubc_core_model.sv
// core-side model: monitored bus cycles, executed instructions, branches
`default_nettype none
module ubc_core_model
  import ubc_pkg::*;
(
  // clock
  input  wire logic     sys_clk,
  // monitored streams
  output ubc_bus_type    busCyc,
  output ubc_exec_type   execInfo,
  output ubc_branch_type branchInfo,
  output logic           branchDone
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    busCyc = '0;
    execInfo = '0;
    branchInfo = '0;
    branchDone = 1'b0;
  end

  // ----------------------------------------
  // transfers
  // ----------------------------------------
  // released fields carry inverted junk so a stale value never matches
  // acc low marks a delay slot; the tests aim one pre break at one on purpose
  task automatic exec(input logic [31:0] a, input logic acc);
    ubc_exec_type e;
    e = '{valid: 1'b1, accept: acc, addr: a, asid: 8'h00};
    @(posedge sys_clk) execInfo <= e;
    e = ~e;
    e.valid = 1'b0;
    @(posedge sys_clk) execInfo <= e;
  endtask

  task automatic bus(input logic [1:0] sz, input logic [31:0] a,
                     input logic dma, input logic wrt,
                     input logic [31:0] d);
    ubc_bus_type b;
    b = '{1'b1, dma, wrt, sz, a, d, 8'h00};
    @(posedge sys_clk) busCyc <= b;
    b = ~b;
    b.valid = 1'b0;
    @(posedge sys_clk) busCyc <= b;
  endtask

  task automatic branch(input logic [27:0] s, input logic [27:0] d);
    ubc_branch_type t;
    t = '{1'b1, 3'h2, s, d};
    @(posedge sys_clk) branchInfo <= t;
    t = ~t;
    t.valid = 1'b0;
    @(posedge sys_clk) branchInfo <= t;
    branchDone <= 1'b1;
    @(posedge sys_clk) branchDone <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> ubc_user_break_tb.sv
// register-level testbench for the user break and pc trace unit
`default_nettype none
module ubc_user_break_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ubc_pkg::*;

  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [7:0]     regAddr = 8'h00;
  logic [31:0]    regWdata = 32'h00000000;
  logic           regWr = 1'b0;
  logic           regRd = 1'b0;
  logic [31:0]    regRdata;
  ubc_bus_type    busCyc;
  ubc_exec_type   execInfo;
  ubc_branch_type branchInfo;
  logic           branchDone;
  logic           brkReq;
  ubc_brk_type    brkType;
  logic [31:0]    brkPc;
  int             n_errors = 0;
  int             checks = 0;
  int             nBrk = 0;

  always #10 sys_clk = ~sys_clk;

  ubc_user_break i_ubc_user_break (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .busCyc(busCyc), .execInfo(execInfo),
    .branchInfo(branchInfo), .branchDone(branchDone), .brkReq(brkReq),
    .brkType(brkType), .brkPc(brkPc));

  ubc_core_model i_ubc_core_model (.sys_clk(sys_clk), .busCyc(busCyc),
    .execInfo(execInfo), .branchInfo(branchInfo), .branchDone(branchDone));

  // counting pulses avoids racing the edge that raises the request
  always @(posedge sys_clk) begin
    if (brkReq === 1'b1) begin
      nBrk++;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk) regWr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk) regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  task automatic wt();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic brk(input int n, input ubc_brk_type t,
                     input logic [31:0] pc);
    wt();
    chk(32'(nBrk), 32'(n));
    chk(32'(brkType), 32'(t));
    chk(brkPc, pc);
  endtask

  task automatic test_done();
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(OFF_ASID_B, 32'h000001A5);
    rdc(OFF_ASID_B, 32'h000000A5);
    rdc(8'h3C, 32'h00000000);
    wr(OFF_ADDR_A, 32'h00000400);
    wr(OFF_MASK_A, 32'h00000000);
    wr(OFF_CTRL, 32'h00300000);
    wr(OFF_BBR_A, 32'h00000014);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    wt();
    chk(32'(nBrk), 32'h0);
    wr(OFF_BBR_A, 32'h00000054);
    i_ubc_core_model.exec(32'h00000400, 1'b0);
    wt();
    chk(32'(nBrk), 32'h0);
    i_ubc_core_model.exec(32'h00000500, 1'b1);
    brk(1, BRK_PRE, 32'h00000500);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    brk(2, BRK_PRE, 32'h00000400);
    rdc(OFF_CTRL, 32'h00308000);
    wr(OFF_CTRL, 32'h00300000);
    rdc(OFF_CTRL, 32'h00300000);
    wr(OFF_CTRL, 32'h00300400);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    i_ubc_core_model.exec(32'h00000402, 1'b1);
    brk(3, BRK_POST, 32'h00000402);
    wr(OFF_CTRL, 32'h00300000);
    wr(OFF_ADDR_A, 32'h00001003);
    wr(OFF_BBR_A, 32'h00000064);
    i_ubc_core_model.bus(SZ_BYTE, 32'h00001002, 1'b0, 1'b0, 32'h00000000);
    i_ubc_core_model.exec(32'h00002000, 1'b1);
    wt();
    chk(32'(nBrk), 32'h3);
    i_ubc_core_model.bus(SZ_LONG, 32'h00001000, 1'b0, 1'b0, 32'h00000000);
    i_ubc_core_model.exec(32'h00002000, 1'b1);
    brk(4, BRK_DATA, 32'h00002000);
    i_ubc_core_model.bus(SZ_WORD, 32'h00001002, 1'b0, 1'b0, 32'h00000000);
    i_ubc_core_model.exec(32'h00002004, 1'b1);
    brk(5, BRK_DATA, 32'h00002004);
    wr(OFF_ADDR_A, 32'h00000400);
    wr(OFF_BBR_A, 32'h00000054);
    wr(OFF_ADDR_B, 32'h00000600);
    wr(OFF_MASK_B, 32'h00000000);
    wr(OFF_BBR_B, 32'h00000054);
    wr(OFF_CTRL, 32'h00300008);
    i_ubc_core_model.exec(32'h00000600, 1'b1);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    wt();
    chk(32'(nBrk), 32'h5);
    i_ubc_core_model.exec(32'h00000600, 1'b1);
    brk(6, BRK_PRE, 32'h00000600);
    wr(OFF_COUNT, 32'h00000002);
    wr(OFF_CTRL, 32'h00300009);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    i_ubc_core_model.exec(32'h00000600, 1'b1);
    wt();
    chk(32'(nBrk), 32'h6);
    rdc(OFF_COUNT, 32'h00000001);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    i_ubc_core_model.exec(32'h00000600, 1'b1);
    brk(7, BRK_PRE, 32'h00000600);
    wr(OFF_CTRL, 32'h00300800);
    i_ubc_core_model.branch(28'h0000123, 28'h0000456);
    rdc(OFF_SRC_TR, 32'hA0000123);
    rdc(OFF_DST_TR, 32'h80000456);
    rdc(OFF_DST_TR, 32'h00000456);
    wr(OFF_ADDR_B, 32'h00055555);
    wr(OFF_BBR_B, 32'h000000A9);
    wr(OFF_DATA_B, 32'h12347878);
    wr(OFF_DMSK_B, 32'h00000F0F);
    wr(OFF_CTRL, 32'h00300080);
    i_ubc_core_model.bus(SZ_BYTE, 32'h00055555, 1'b1, 1'b1,
      32'h00007A65);
    i_ubc_core_model.exec(32'h00003000, 1'b1);
    wt();
    chk(32'(nBrk), 32'h7);
    i_ubc_core_model.bus(SZ_BYTE, 32'h00055555, 1'b1, 1'b1,
      32'hFFFF7A75);
    i_ubc_core_model.exec(32'h00003000, 1'b1);
    brk(8, BRK_DATA, 32'h00003000);
    i_ubc_core_model.bus(SZ_BYTE, 32'h00055555, 1'b1, 1'b1,
      32'hFFFF7A75);
    i_ubc_core_model.exec(32'h00000400, 1'b1);
    brk(9, BRK_PRE, 32'h00000400);
    rdc(OFF_CTRL, 32'h00309080);
    test_done();
  end
endmodule
`default_nettype wire
